// ==== lfsc_ctrl.sv ====
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "lfsc_defines.svh"
`default_nettype none

// Functional notes
// - Display select 0 blanks, 1 shows RAM
// - Subclock undivided, halved, quartered; bit2 ignored
// - System clock divided by 2 to 256
// - System-clock selection stops in sub modes
// - Subclock frames 128, 64, 32 Hz
// - 250 kHz dividers give 488 to 3.8 Hz
// - One-third duty runs frames four-thirds faster
// - Second register resets 0x60, bits 6:5 fixed
// - Bit 7 selects A or B waveform
// - Bit 4 picks 5 V source and regulator
// - Charge duty codes: high, n/8, low, 1/16, 1/32
// - Pulse duty sets split-resistance connected fraction
// - Zero duty keeps split-resistance connected
// - Standby bit 0 parks controller, resets 1
// - Clearing activate halts, supply off, registers kept
// - Power switch gated by activate and standby
module lfsc_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Clock sources as enables
  input wire logic subclk_en,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Panel side controls
  output lfsc_pkg::lfsc_out_type lcd_out
);

  typedef struct packed {
    lfsc_pkg::lfsc_main_type main;
    lfsc_pkg::lfsc_wave_type wave;
    lfsc_pkg::lfsc_ckstp_type ckstp;
    lfsc_pkg::lfsc_mode_type mode;
    lfsc_pkg::lfsc_wstate_type wst;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] sysdiv;
    logic [1:0] subdiv;
    logic [7:0] fcnt;
    logic [4:0] ccnt;
    lfsc_pkg::lfsc_out_type out;
  } lfsc_state_type;

  lfsc_state_type state_ff;
  lfsc_state_type nxt_state;

  logic wr_fire;
  logic rd_fire;
  logic op_tick;
  logic running;
  logic frame_end;
  logic split_on;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic [7:0] wb;

  // Address and data taken together, so either order from the master is fine
  assign s_axi_awready = (state_ff.wst == lfsc_pkg::LFSC_W_IDLE) && s_axi_wvalid;
  assign s_axi_wready = (state_ff.wst == lfsc_pkg::LFSC_W_IDLE) && s_axi_awvalid;
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  assign s_axi_bvalid = (state_ff.wst == lfsc_pkg::LFSC_W_RESP);
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_arready = !state_ff.rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rresp = state_ff.rresp;
  assign s_axi_rdata = state_ff.rdata;
  assign lcd_out = state_ff.out;
  assign wb = s_axi_wdata[7:0];

  // Controller runs only when activated and out of module standby
  assign running = state_ff.main.controller_activate && state_ff.ckstp.lcd_run;

  always_comb begin
    rd_ok = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr)
      `LFSC_OFS_MAIN: rd_byte = `LFSC_MAIN_FIXED | {1'b0, state_ff.main};
      `LFSC_OFS_WAVE: rd_byte = `LFSC_WAVE_FIXED | {state_ff.wave.ab, 2'b00,
                                state_ff.wave.boost_supply_select,
                                state_ff.wave.charge_pulse_duty_select};
      `LFSC_OFS_CKSTP: rd_byte = `LFSC_CKSTP_FIXED | {3'b000, state_ff.ckstp};
      `LFSC_OFS_MODE: rd_byte = {5'h00, state_ff.mode};
      `LFSC_OFS_STAT: rd_byte = {2'b00, state_ff.out};
      default: rd_ok = 1'b0;
    endcase
  end

  // Operating clock tick from the selected source
  always_comb begin
    op_tick = 1'b0;
    if (state_ff.main.frame_clock_select[3]) begin
      // Halted system clock in sub modes: no ticks, display stops
      if (!state_ff.mode.sub_mode) begin
        case (state_ff.main.frame_clock_select[2:0])
          3'h0: op_tick = state_ff.sysdiv[0] == 1'b1;
          3'h1: op_tick = state_ff.sysdiv[1:0] == 2'h3;
          3'h2: op_tick = state_ff.sysdiv[2:0] == 3'h7;
          3'h3: op_tick = state_ff.sysdiv[3:0] == 4'hF;
          3'h4: op_tick = state_ff.sysdiv[4:0] == 5'h1F;
          3'h5: op_tick = state_ff.sysdiv[5:0] == 6'h3F;
          3'h6: op_tick = state_ff.sysdiv[6:0] == 7'h7F;
          default: op_tick = state_ff.sysdiv == 8'hFF;
        endcase
      end
    end else begin
      case (state_ff.main.frame_clock_select[1:0])
        2'h0: op_tick = subclk_en;
        2'h1: op_tick = subclk_en && state_ff.subdiv[0];
        default: op_tick = subclk_en && (state_ff.subdiv == 2'h3);
      endcase
    end
  end

  // Shorter frame for one-third duty gives the 4/3 rate
  assign frame_end = state_ff.mode.duty3 ?
    (state_ff.fcnt == 8'(`LFSC_FRAME_TICKS_DUTY3 - 1)) :
    (state_ff.fcnt == 8'(`LFSC_FRAME_TICKS - 1));

  // Connected share of the charge period
  always_comb begin
    split_on = 1'b0;
    casez (state_ff.wave.charge_pulse_duty_select)
      4'b0000: split_on = 1'b1;
      4'b0111: split_on = 1'b0;
      4'b10??: split_on = state_ff.ccnt[4:1] == 4'h0;
      4'b11??: split_on = state_ff.ccnt == 5'h00;
      default: split_on = state_ff.ccnt[2:0] < state_ff.wave.charge_pulse_duty_select[2:0];
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.out.frame_tick = 1'b0;
    if (wr_fire) begin
      nxt_state.wst = lfsc_pkg::LFSC_W_RESP;
      nxt_state.bresp = `LFSC_RESP_OKAY;
      if (s_axi_wstrb[0]) begin
        case (s_axi_awaddr)
          `LFSC_OFS_MAIN: nxt_state.main = wb[6:0];
          `LFSC_OFS_WAVE: nxt_state.wave = {wb[7], wb[4:0]};
          `LFSC_OFS_CKSTP: nxt_state.ckstp = wb[4:0];
          `LFSC_OFS_MODE: nxt_state.mode = wb[2:0];
          `LFSC_OFS_STAT: nxt_state.bresp = `LFSC_RESP_OKAY;
          default: nxt_state.bresp = `LFSC_RESP_SLVERR;
        endcase
      end else if (!(s_axi_awaddr inside {`LFSC_OFS_MAIN, `LFSC_OFS_WAVE,
                   `LFSC_OFS_CKSTP, `LFSC_OFS_MODE, `LFSC_OFS_STAT})) begin
        nxt_state.bresp = `LFSC_RESP_SLVERR;
      end
    end
    case (state_ff.wst)
      lfsc_pkg::LFSC_W_IDLE: begin
      end
      lfsc_pkg::LFSC_W_RESP: begin
        if (s_axi_bready) begin
          nxt_state.wst = lfsc_pkg::LFSC_W_IDLE;
        end
      end
      default: nxt_state.wst = lfsc_pkg::LFSC_W_IDLE;
    endcase
    if (rd_fire) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = {24'h000000, rd_byte};
      nxt_state.rresp = rd_ok ? `LFSC_RESP_OKAY : `LFSC_RESP_SLVERR;
    end else if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    // Dividers clear while halted so restart begins on a clean frame
    if (running) begin
      nxt_state.sysdiv = state_ff.sysdiv + 8'h01;
      if (subclk_en) begin
        nxt_state.subdiv = state_ff.subdiv + 2'h1;
      end
      if (op_tick) begin
        if (frame_end) begin
          nxt_state.fcnt = 8'h00;
          nxt_state.out.frame_tick = 1'b1;
          nxt_state.ccnt = state_ff.ccnt + 5'h01;
        end else begin
          nxt_state.fcnt = state_ff.fcnt + 8'h01;
        end
      end
    end else begin
      nxt_state.sysdiv = 8'h00;
      nxt_state.subdiv = 2'h0;
      nxt_state.fcnt = 8'h00;
      nxt_state.ccnt = 5'h00;
    end
    nxt_state.out.blank = !(state_ff.main.display_data_select && running);
    nxt_state.out.wave_b = state_ff.wave.ab;
    nxt_state.out.boost_on = state_ff.wave.boost_supply_select && running;
    nxt_state.out.drive_on = state_ff.main.drive_power_switch && running
                             && !state_ff.mode.chip_standby;
    nxt_state.out.split_conn = running && split_on;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff.main <= 7'h00;
      state_ff.wave <= 6'h00;
      state_ff.ckstp <= 5'h1F;
      state_ff.mode <= 3'(`LFSC_RST_MODE);
      state_ff.wst <= lfsc_pkg::LFSC_W_IDLE;
      state_ff.bresp <= `LFSC_RESP_OKAY;
      state_ff.rvalid <= 1'b0;
      state_ff.rresp <= `LFSC_RESP_OKAY;
      state_ff.rdata <= 32'h00000000;
      state_ff.sysdiv <= 8'h00;
      state_ff.subdiv <= 2'h0;
      state_ff.fcnt <= 8'h00;
      state_ff.ccnt <= 5'h00;
      state_ff.out <= 6'h04;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule : lfsc_ctrl
`default_nettype wire

// ==== lfsc_defines.svh ====
`ifndef LFSC_DEFINES_SVH
`define LFSC_DEFINES_SVH

// Byte offsets of the AXI4-Lite register map
`define LFSC_OFS_MAIN 8'h00
`define LFSC_OFS_WAVE 8'h04
`define LFSC_OFS_CKSTP 8'h08
`define LFSC_OFS_MODE 8'h0C
`define LFSC_OFS_STAT 8'h10

// Reset values
`define LFSC_RST_MAIN 8'h80
`define LFSC_RST_WAVE 8'h60
`define LFSC_RST_CKSTP 8'hFF
`define LFSC_RST_MODE 8'h00

// Reserved bits that always read as one
`define LFSC_MAIN_FIXED 8'h80
`define LFSC_WAVE_FIXED 8'h60
`define LFSC_CKSTP_FIXED 8'hF0

// Field positions
`define LFSC_MAIN_PWR_BIT 6
`define LFSC_MAIN_RUN_BIT 5
`define LFSC_MAIN_SHOW_BIT 4
`define LFSC_WAVE_AB_BIT 7
`define LFSC_WAVE_BOOST_BIT 4
`define LFSC_CKSTP_LCD_BIT 0

// AXI responses
`define LFSC_RESP_OKAY 2'b00
`define LFSC_RESP_SLVERR 2'b10

// Frame timing: one frame spans this many operating clock ticks
`define LFSC_FRAME_TICKS 256
`define LFSC_FRAME_TICKS_DUTY3 192
// Charge pulse period in frame ticks (eighths need 8, 1/32 needs 32)
`define LFSC_CHG_PERIOD 32

`endif

// ==== lfsc_pkg.sv ====
`default_nettype none
package lfsc_pkg;

  typedef struct packed {
    logic drive_power_switch;
    logic controller_activate;
    logic display_data_select;
    logic [3:0] frame_clock_select;
  } lfsc_main_type;

  typedef struct packed {
    logic ab;
    logic boost_supply_select;
    logic [3:0] charge_pulse_duty_select;
  } lfsc_wave_type;

  typedef struct packed {
    logic [3:0] other;
    logic lcd_run;
  } lfsc_ckstp_type;

  typedef struct packed {
    logic duty3;
    logic sub_mode;
    logic chip_standby;
  } lfsc_mode_type;

  typedef enum logic [2:0] {
    LFSC_W_IDLE = 3'b001,
    LFSC_W_RESP = 3'b010,
    LFSC_W_HOLD = 3'b100
  } lfsc_wstate_type;

  typedef struct packed {
    logic drive_on;
    logic boost_on;
    logic wave_b;
    logic blank;
    logic frame_tick;
    logic split_conn;
  } lfsc_out_type;

endpackage : lfsc_pkg
`default_nettype wire

// ==== lfsc_monitor.sv ====
`default_nettype none
module lfsc_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Panel side
  input wire lfsc_pkg::lfsc_out_type lcd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturates so a long idle never wraps into a false short gap
  logic [9:0] gap_ff;
  always_ff @(posedge aclk)
    if (!aresetn || lcd_out.frame_tick) gap_ff <= 10'h000;
    else if (gap_ff != 10'h3FF) gap_ff <= gap_ff + 10'h001;
  a_tick_one_cycle: assert property (lcd_out.frame_tick |=> !lcd_out.frame_tick)
    else $error("frame tick too wide");
  a_frame_min_gap: assert property (lcd_out.frame_tick |-> gap_ff >= 10'h17F)
    else $error("frame ticks too close");
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
    |=> s_axi_bvalid)
    else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_no_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0)
    else $error("error read data not zero");
endmodule : lfsc_monitor
bind lfsc_ctrl lfsc_monitor u_mon (.*);
`default_nettype wire

// ==== lfsc_panel.sv ====
`default_nettype none
module lfsc_panel (
  // Clock
  input wire logic aclk,
  // Controller drive
  input wire lfsc_pkg::lfsc_out_type lcd_out,
  // Frame timing seen at the glass
  output int n_frames,
  output int period,
  // Bias source the glass expects
  output logic ext_bias
);
  timeunit 1ns;
  timeprecision 1ps;
  int since;
  // Split resistance off: bias comes from outside
  assign ext_bias = !lcd_out.split_conn;
  initial begin
    n_frames = 0;
    period = 0;
    since = 0;
  end
  always @(posedge aclk) begin
    since <= since + 1;
    if (lcd_out.frame_tick) begin
      period <= since + 1;
      n_frames <= n_frames + 1;
      since <= 0;
    end
  end
endmodule : lfsc_panel
`default_nettype wire

// ==== tb_lcd_frame_and_supply_control.sv ====
`default_nettype none
module tb_lcd_frame_and_supply_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, subclk_en = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  lfsc_pkg::lfsc_out_type lcd_out;
  logic ext_bias;
  int fail_count = 0, n_tests = 0, n_frames, period, sc = 0;
  lfsc_ctrl dut (.*);
  lfsc_panel u_panel (.aclk, .lcd_out, .n_frames, .period, .ext_bias);
  always #12.5 aclk = ~aclk;
  // Fast stand-in subclock keeps subclock frames short
  always @(posedge aclk) begin
    sc <= (sc == 3) ? 0 : sc + 1;
    subclk_en <= (sc == 3);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge aclk iff (s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge aclk iff s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk iff s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Status reads mask the frame tick, which is only a pulse
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFF);
    rd(a);
    chk(rv & m, e);
  endtask : rc
  task automatic frm(input int exp);
    int n;
    n = n_frames;
    wait (n_frames == n + 2);
    chk(period, exp);
  endtask : frm
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  initial begin
    #2500000;
    fail_count++;
    stop_test();
  end
  initial begin
    int n;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h00, 32'h80);
    rc(8'h04, 32'h60);
    rc(8'h08, 32'hFF);
    rc(8'h10, 32'h04);
    wr(8'h04, 32'h00);
    rc(8'h04, 32'h60);
    wr(8'h04, 32'hFF);
    rc(8'h04, 32'hFF);
    rd(8'h20);
    chk(rr, 2'h2);
    $display("registers done");
    wr(8'h04, 32'h90);
    wr(8'h00, 32'hF8);
    rc(8'h10, 32'h39, 32'h3D);
    chk(ext_bias, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'hF8 + i);
      frm(512 << i);
    end
    wr(8'h00, 32'hD8);
    rc(8'h10, 32'h0C, 32'h3D);
    rc(8'h00, 32'hD8);
    wr(8'h0C, 32'h04);
    wr(8'h00, 32'hF8);
    frm(384);
    wr(8'h0C, 32'h00);
    $display("system clock frames done");
    wr(8'h00, 32'hF0);
    frm(1024);
    wr(8'h00, 32'hF1);
    frm(2048);
    wr(8'h00, 32'hF6);
    frm(4096);
    wr(8'h0C, 32'h02);
    wr(8'h00, 32'hF8);
    // Let a tick launched under the old selection land first
    repeat (2) @(posedge aclk);
    n = n_frames;
    repeat (3000) @(posedge aclk);
    chk(n_frames, n);
    wr(8'h00, 32'hF0);
    frm(1024);
    $display("subclock frames done");
    wr(8'h04, 32'h87);
    rc(8'h10, 32'h28, 32'h3D);
    chk(ext_bias, 1'b1);
    wr(8'h0C, 32'h01);
    rc(8'h10, 32'h08, 32'h3D);
    wr(8'h08, 32'hFE);
    rc(8'h10, 32'h0C, 32'h3D);
    rc(8'h08, 32'hFE);
    wr(8'h08, 32'hFF);
    wr(8'h0C, 32'h00);
    wr(8'h00, 32'hE0);
    rc(8'h10, 32'h2C, 32'h3D);
    $display("supply and blanking done");
    stop_test();
  end
endmodule : tb_lcd_frame_and_supply_control
`default_nettype wire
